/* common/udc_defines.svh */
`ifndef UDC_DEFINES_SVH
`define UDC_DEFINES_SVH
`define UDC_CNT_W 4
`define UDC_CNT_RST 4'h0
`define UDC_CNT_MAX 4'hf
`define UDC_CNT_MIN 4'h0
`define UDC_SYNC_RST 3'h0
`endif

/* common/udc_pkg.sv */
package udc_pkg;
	typedef struct packed {
		logic countUp;
		logic countDown;
		logic masterClear;
		logic presetStrobe_n;
	} udc_ctl_t;
	typedef enum logic [1:0] {
		UDC_IDLE = 2'b00,
		UDC_UP = 2'b01,
		UDC_DOWN = 2'b10,
		UDC_MISUSE = 2'b11
	} udc_evt_t;
endpackage

/* hw/udc_counter4.sv */
`timescale 1ns/1ps
`include "udc_defines.svh"
module udc_counter4 #(
	parameter int CNT_W = `UDC_CNT_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic count_up_clock,
	input wire logic count_down_clock,
	input wire logic master_clear,
	input wire logic preset_strobe_n,
	input wire logic [CNT_W-1:0] preset_value,
	output logic [CNT_W-1:0] count_value,
	output logic carry_out_n,
	output logic borrow_out_n,
	output logic misuse_pulse
);
	// Pins are asynchronous to clk: control pins get three stages, change counted when stages 2 and 3 agree; preset_value gets two stages
	logic [2:0] upSync_ff;
	logic [2:0] dnSync_ff;
	logic [2:0] clrSync_ff;
	logic [2:0] preSync_ff;
	logic [CNT_W-1:0] preVal1_ff;
	logic [CNT_W-1:0] preVal2_ff;
	logic upLvl_ff;
	logic dnLvl_ff;
	logic clrLvl_ff;
	logic preLvl_ff;
	logic [CNT_W-1:0] nxt_preVal2;
	logic [CNT_W-1:0] nxt_preVal1;
	logic [2:0] nxt_upSync;
	logic [2:0] nxt_dnSync;
	logic [2:0] nxt_clrSync;
	logic [2:0] nxt_preSync;
	logic nxt_upLvl;
	logic nxt_dnLvl;
	logic nxt_clrLvl;
	logic nxt_preLvl;

	function automatic logic agreed(input logic [2:0] s, input logic cur);
		agreed = (s[1] == s[2]) ? s[2] : cur;
	endfunction

	always_comb begin
		nxt_upSync = {upSync_ff[1:0], count_up_clock};
		nxt_dnSync = {dnSync_ff[1:0], count_down_clock};
		nxt_clrSync = {clrSync_ff[1:0], master_clear};
		nxt_preSync = {preSync_ff[1:0], preset_strobe_n};
		nxt_upLvl = agreed(upSync_ff, upLvl_ff);
		nxt_dnLvl = agreed(dnSync_ff, dnLvl_ff);
		nxt_clrLvl = agreed(clrSync_ff, clrLvl_ff);
		nxt_preLvl = agreed(preSync_ff, preLvl_ff);
		nxt_preVal1 = preset_value;
		nxt_preVal2 = preVal1_ff;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			upSync_ff <= 3'h7;
			dnSync_ff <= 3'h7;
			clrSync_ff <= `UDC_SYNC_RST;
			preSync_ff <= 3'h7;
			upLvl_ff <= 1'b1;
			dnLvl_ff <= 1'b1;
			clrLvl_ff <= 1'b0;
			preLvl_ff <= 1'b1;
			preVal1_ff <= `UDC_CNT_RST;
			preVal2_ff <= `UDC_CNT_RST;
		end else begin
			upSync_ff <= nxt_upSync;
			dnSync_ff <= nxt_dnSync;
			clrSync_ff <= nxt_clrSync;
			preSync_ff <= nxt_preSync;
			upLvl_ff <= nxt_upLvl;
			dnLvl_ff <= nxt_dnLvl;
			clrLvl_ff <= nxt_clrLvl;
			preLvl_ff <= nxt_preLvl;
			preVal1_ff <= nxt_preVal1;
			preVal2_ff <= nxt_preVal2;
		end
	end

	// Counter state and terminal-count outputs
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic carry_ff;
	logic borrow_ff;
	logic misuse_ff;
	logic nxt_carry;
	logic nxt_borrow;
	logic nxt_misuse;
	logic upRise;
	logic dnRise;
	udc_pkg::udc_evt_t evt;

	assign upRise = nxt_upLvl & ~upLvl_ff;
	assign dnRise = nxt_dnLvl & ~dnLvl_ff;

	always_comb begin
		if (upRise && nxt_dnLvl && !dnRise) begin
			evt = udc_pkg::UDC_UP;
		end else if (dnRise && nxt_upLvl && !upRise) begin
			evt = udc_pkg::UDC_DOWN;
		end else if (upRise || dnRise) begin
			evt = udc_pkg::UDC_MISUSE;
		end else begin
			evt = udc_pkg::UDC_IDLE;
		end
	end

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_misuse = 1'b0;
		if (nxt_clrLvl) begin
			nxt_cnt = `UDC_CNT_RST;
		end else if (!nxt_preLvl) begin
			nxt_cnt = preVal2_ff;
		end else begin
			// Level tracking runs during clear/preset, so a low clock still rises later
			case (evt)
				udc_pkg::UDC_UP: begin
					nxt_cnt = cnt_ff + 4'h1;
				end
				udc_pkg::UDC_DOWN: begin
					nxt_cnt = cnt_ff - 4'h1;
				end
				udc_pkg::UDC_MISUSE: begin
					// Hold rather than guess the by-two case
					nxt_misuse = 1'b1;
				end
				default: begin
					nxt_cnt = cnt_ff;
				end
			endcase
		end
		// Decoded from next count so outputs stay aligned with count_value
		nxt_carry = ~((nxt_cnt == `UDC_CNT_MAX) && !nxt_upLvl);
		nxt_borrow = ~((nxt_cnt == `UDC_CNT_MIN) && !nxt_dnLvl);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= `UDC_CNT_RST;
			carry_ff <= 1'b1;
			borrow_ff <= 1'b1;
			misuse_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			carry_ff <= nxt_carry;
			borrow_ff <= nxt_borrow;
			misuse_ff <= nxt_misuse;
		end
	end

	assign count_value = cnt_ff;
	assign carry_out_n = carry_ff;
	assign borrow_out_n = borrow_ff;
	assign misuse_pulse = misuse_ff;

	a_count_up: assert property (@(posedge clk) disable iff (sys_rst)
		(upRise && nxt_dnLvl && !dnRise && !nxt_clrLvl && nxt_preLvl)
		|=> (cnt_ff == $past(cnt_ff) + 4'h1))
		else $error("count up missed");
	a_count_down: assert property (@(posedge clk) disable iff (sys_rst)
		(dnRise && nxt_upLvl && !upRise && !nxt_clrLvl && nxt_preLvl)
		|=> (cnt_ff == $past(cnt_ff) - 4'h1))
		else $error("count down missed");
	a_clear_wins: assert property (@(posedge clk) disable iff (sys_rst)
		nxt_clrLvl |=> (cnt_ff == 4'h0))
		else $error("clear did not zero count");
	a_preset_load: assert property (@(posedge clk) disable iff (sys_rst)
		(!nxt_clrLvl && !nxt_preLvl) |=> (cnt_ff == $past(preVal2_ff)))
		else $error("preset value not loaded");
	a_carry_mirror: assert property (@(posedge clk) disable iff (sys_rst)
		(cnt_ff == 4'hf && !upLvl_ff) |-> !carry_out_n)
		else $error("carry not low at fifteen");
	a_borrow_mirror: assert property (@(posedge clk) disable iff (sys_rst)
		(cnt_ff == 4'h0 && !dnLvl_ff) |-> !borrow_out_n)
		else $error("borrow not low at zero");
	a_tc_rest: assert property (@(posedge clk) disable iff (sys_rst)
		(cnt_ff != 4'hf && cnt_ff != 4'h0) |-> (carry_out_n && borrow_out_n))
		else $error("terminal output low away from terminal count");
	a_misuse_hold: assert property (@(posedge clk) disable iff (sys_rst)
		misuse_pulse |-> $stable(cnt_ff) ##1 !misuse_pulse [*1])
		else $error("misuse changed count");
	a_wrap_up: assert property (@(posedge clk) disable iff (sys_rst)
		($past(cnt_ff) == 4'hf && !$past(nxt_clrLvl) && $past(nxt_preLvl)
		&& $past(evt) == udc_pkg::UDC_UP) |-> cnt_ff == 4'h0)
		else $error("up wrap wrong");
	a_wrap_down: assert property (@(posedge clk) disable iff (sys_rst)
		(cnt_ff == 4'h0 && evt == udc_pkg::UDC_DOWN && !nxt_clrLvl && nxt_preLvl)
		|=> (cnt_ff == 4'hf))
		else $error("down wrap wrong");
	a_misuse_both: assert property (@(posedge clk) disable iff (sys_rst)
		(upRise && dnRise && !nxt_clrLvl && nxt_preLvl)
		|=> (misuse_pulse && $stable(cnt_ff)))
		else $error("simultaneous rise not flagged");
	a_carry_rest: assert property (@(posedge clk) disable iff (sys_rst)
		(upLvl_ff && dnLvl_ff) |-> (carry_out_n && borrow_out_n))
		else $error("terminal output low with clocks high");
endmodule // udc_counter4

/* tb/udc_clk_drv.sv */
`timescale 1ns/1ps
module udc_clk_drv (
	input wire logic clk,
	output logic upClk,
	output logic downClk
);
	initial begin
		upClk = 1'h1;
		downClk = 1'h1;
	end
	// Each level held 8 cycles, well past the 3-cycle sync minimum
	task automatic drive(input logic u, input logic d);
		@(posedge clk);
		upClk <= u;
		downClk <= d;
		repeat (8) @(posedge clk);
	endtask
	// Idle clock stays high, so reversal only happens between counts
	task automatic count(input logic up);
		drive(!up, up);
		drive(1'h1, 1'h1);
	endtask
endmodule // udc_clk_drv

/* tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
	logic clk, sysRst, masterClear, presetStrobe_n;
	logic [3:0] presetValue;
	logic [3:0] countValue;
	logic carryOut_n, borrowOut_n, misusePulse, upClk, downClk;
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;
	int misuseCnt = 0;
	udc_clk_drv u_drv (.clk(clk), .upClk(upClk), .downClk(downClk));
	udc_counter4 u_dut (.clk(clk), .sys_rst(sysRst), .count_up_clock(upClk),
		.count_down_clock(downClk), .master_clear(masterClear),
		.preset_strobe_n(presetStrobe_n), .preset_value(presetValue),
		.count_value(countValue), .carry_out_n(carryOut_n),
		.borrow_out_n(borrowOut_n), .misuse_pulse(misusePulse));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// Misuse is a one-cycle pulse, so count it for later inspection
	always @(posedge clk) begin
		cyc++;
		if (misusePulse === 1'h1) misuseCnt++;
		if (cyc == 1000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic ctl(input logic mc, input logic ps);
		@(posedge clk);
		masterClear <= mc;
		presetStrobe_n <= ps;
		repeat (8) @(posedge clk);
	endtask
	task automatic chk3(input string n, input logic [3:0] c, input logic cy, input logic bo);
		// Sample away from the edge that launches the outputs
		@(negedge clk);
		`CHK(n, c, countValue)
		`CHK(n, cy, carryOut_n)
		`CHK(n, bo, borrowOut_n)
	endtask
	task automatic t_wrap();
		chk3("reset", 4'h0, 1'h1, 1'h1);
		u_drv.drive(1'h1, 1'h0);
		chk3("zero low", 4'h0, 1'h1, 1'h0);
		u_drv.drive(1'h1, 1'h1);
		chk3("down wrap", 4'hf, 1'h1, 1'h1);
		u_drv.drive(1'h0, 1'h1);
		chk3("max low", 4'hf, 1'h0, 1'h1);
		u_drv.drive(1'h1, 1'h1);
		chk3("up wrap", 4'h0, 1'h1, 1'h1);
	endtask
	task automatic t_load();
		ctl(1'h0, 1'h0);
		chk3("load", 4'ha, 1'h1, 1'h1);
		ctl(1'h1, 1'h0);
		chk3("clear over load", 4'h0, 1'h1, 1'h1);
		ctl(1'h0, 1'h1);
		chk3("released", 4'h0, 1'h1, 1'h1);
	endtask
	task automatic t_low_through_clear();
		u_drv.drive(1'h0, 1'h1);
		ctl(1'h1, 1'h1);
		ctl(1'h0, 1'h1);
		u_drv.drive(1'h1, 1'h1);
		chk3("count after clear", 4'h1, 1'h1, 1'h1);
	endtask
	task automatic t_reverse_misuse();
		int misuseBase;
		u_drv.count(1'h1);
		u_drv.count(1'h1);
		u_drv.count(1'h0);
		chk3("reverse", 4'h2, 1'h1, 1'h1);
		misuseBase = misuseCnt;
		u_drv.drive(1'h0, 1'h0);
		u_drv.drive(1'h1, 1'h1);
		chk3("misuse held", 4'h2, 1'h1, 1'h1);
		`CHK("misuse flag", misuseBase + 1, misuseCnt)
	endtask
	task automatic t_mid_reset();
		@(posedge clk);
		sysRst <= 1'h1;
		repeat (2) @(posedge clk);
		sysRst <= 1'h0;
		chk3("mid reset", 4'h0, 1'h1, 1'h1);
		u_drv.count(1'h1);
		chk3("count after reset", 4'h1, 1'h1, 1'h1);
	endtask
	initial begin
		sysRst = 1'h1;
		masterClear = 1'h0;
		presetStrobe_n = 1'h1;
		presetValue = 4'ha;
		repeat (2) @(posedge clk);
		sysRst <= 1'h0;
		repeat (2) @(posedge clk);
		t_wrap();
		t_load();
		t_low_through_clear();
		t_reverse_misuse();
		t_mid_reset();
		summarize();
	end
endmodule // testbench
